/* File: src/vaddsub_params.svh */
// constants for the vector integer add/subtract unit
`ifndef VADDSUB_PARAMS_SVH
`define VADDSUB_PARAMS_SVH
`define VAS_MAX_EW 64
`define VAS_IMM_W 5
`define VAS_EW_W 2
`define VAS_EW8 2'h0
`define VAS_EW16 2'h1
`define VAS_EW32 2'h2
`define VAS_EW64 2'h3
`define VAS_MUL_W 3
`define VAS_MUL_MIN 3'h5
`define VAS_MUL_MAX 3'h3
`define VAS_MUL_FRAC 3'h4
`endif

/* File: src/vaddsub_pkg.sv */
// types shared by the vector integer add/subtract unit
`include "vaddsub_params.svh"
package vaddsub_pkg;
    typedef enum logic [4:0] {
        OP_ADD, OP_SUB, OP_RSUB,
        OP_WADDU, OP_WADD, OP_WSUBU, OP_WSUB,
        OP_WADDU_W, OP_WADD_W, OP_WSUBU_W, OP_WSUB_W,
        OP_ZEXT2, OP_SEXT2, OP_ZEXT4, OP_SEXT4, OP_ZEXT8, OP_SEXT8,
        OP_ADC, OP_MADC, OP_SBC, OP_MSBC,
        OP_MACC, OP_MADD
    } op_e;
    typedef enum logic [1:0] {
        FORM_VV, FORM_VX, FORM_VI
    } form_e;
    typedef struct packed {
        op_e op;
        form_e form;
        logic [`VAS_EW_W-1:0] elemWidth;
        logic [`VAS_MUL_W-1:0] groupMul;
        logic maskEnable;
        logic [4:0] destReg;
    } ctrl_s;
    typedef struct packed {
        logic [`VAS_MAX_EW-1:0] first;
        logic [`VAS_MAX_EW-1:0] second;
        logic [`VAS_MAX_EW-1:0] scalar;
        logic [`VAS_IMM_W-1:0] imm;
        logic [`VAS_MAX_EW-1:0] oldDest;
        logic carryIn;
    } operands_s;
    typedef struct packed {
        logic [`VAS_MAX_EW-1:0] value;
        logic maskBit;
        logic isMask;
        logic tailAgnostic;
        logic [`VAS_EW_W-1:0] destWidth;
        logic [`VAS_MUL_W-1:0] destMul;
    } result_s;
endpackage

/* File: src/vaddsub_elem.sv */
// one element lane: add or subtract with carry in and a result one bit wider
`timescale 1ns/1ps
`include "vaddsub_params.svh"
module vaddsub_elem
    import vaddsub_pkg::*;
#(
    parameter int W = `VAS_MAX_EW
)(
    // operands already placed for the lane
    input wire logic [W-1:0] opA,
    input wire logic [W-1:0] opB,
    input wire logic subtract,
    input wire logic carryIn,
    // outputs
    output logic [W-1:0] sum,
    output logic [W:0] wide
);
    // the narrowest element is a byte; a smaller lane cannot hold one
    if (W < 8)
    begin : g_width_check
        $error("lane width too small");
    end
    always_comb
    begin
        // untruncated: for subtract the top bit is the borrow
        if (subtract)
            wide = {1'b0, opA} - {1'b0, opB} - {{W{1'b0}}, carryIn};
        else
            wide = {1'b0, opA} + {1'b0, opB} + {{W{1'b0}}, carryIn};
        sum = wide[W-1:0];
    end
endmodule

/* File: src/vaddsub_unit.sv */
// element-wise vector integer add, subtract, widen, extend and carry unit
// Notes on behaviour
// - first source is vector; scalar/immediate is second operand
// - integer multiply-add: accumulate or overwrite multiplicand forms
// - widening writes twice width, twice group multiplier
// - widening first source single or double width
// - results wrap modulo element width, no trap
// - add in three forms, subtract in two
// - reverse subtract: scalar minus element, not vector-vector
// - widening signed/unsigned extend sources before arithmetic
// - double-width first source plus extended second source
// - extension from half, quarter or eighth width
// - extension illegal width or group is reserved
// - carry input always from mask register zero
// - carry ops: value result and mask result
// - add/sub with carry need mask-enable cleared
// - carry-out uses carry-in only when mask-enable cleared
// - carry-out results always tail-agnostic
// - immediate sign-extended to element width
// - scalar truncated or sign-extended to element width
// - borrow set when untruncated difference negative
// - carry value ops into register zero reserved
`timescale 1ns/1ps
`include "vaddsub_params.svh"
module vaddsub_unit
    import vaddsub_pkg::*;
#(
    parameter int XLEN = 64
)(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request from issue logic
    input wire logic inValid,
    input wire ctrl_s ctrl,
    input wire operands_s operands,
    input wire logic [XLEN-1:0] scalarReg,
    // answer
    output logic outValid,
    output result_s result,
    output logic reserved
);
    localparam int MW = `VAS_MAX_EW;

    // only the two scalar widths whose truncation and extension are coded below
    if (XLEN != 32 && XLEN != 64)
    begin : g_xlen_check
        $error("scalar width unsupported");
    end

    function automatic int ewBits(input logic [`VAS_EW_W-1:0] code);
        ewBits = 8 << code;
    endfunction

    // width-limited mask, sign and zero extension at a given bit count
    function automatic logic [MW-1:0] fitTo(input logic [MW-1:0] v, input int bits, input logic sgn);
        logic [MW-1:0] r;
        r = '0;
        for (int i = 0; i < MW; i++)
        begin
            if (i < bits)
                r[i] = v[i];
            else
                r[i] = sgn & v[bits-1];
        end
        fitTo = r;
    endfunction

    // group multiplier code is signed log2; lower bound fixed
    function automatic logic [`VAS_MUL_W-1:0] mulShift(input logic [`VAS_MUL_W-1:0] m, input int d);
        mulShift = m + d[`VAS_MUL_W-1:0];
    endfunction

    // log2 of the extension ratio: half, quarter or eighth source
    function automatic int extShift(input op_e op);
        unique case (op)
            OP_ZEXT2, OP_SEXT2: extShift = 1;
            OP_ZEXT4, OP_SEXT4: extShift = 2;
            default: extShift = 3;
        endcase
    endfunction

    // per-operation settings captured with the request
    logic valid_r, valid_nxt;
    result_s res_r, res_nxt;
    logic rsv_r, rsv_nxt;

    int ew;
    logic [MW-1:0] second;
    logic [MW-1:0] opA, opB;
    logic doSub, cin, isWide, wSigned, extSigned;
    int extBits;
    logic [MW-1:0] laneSum;
    logic [MW:0] laneWide;
    logic [MW-1:0] prod;
    logic [MW-1:0] fullSum;
    int outBits;

    vaddsub_elem #(.W(MW)) lane (
        .opA(opA),
        .opB(opB),
        .subtract(doSub),
        .carryIn(cin),
        .sum(laneSum),
        .wide(laneWide)
    );

    always_comb
    begin
        ew = ewBits(ctrl.elemWidth);
        // choose second operand: vector, scalar register or immediate
        unique case (ctrl.form)
            FORM_VV: second = fitTo(operands.second, ew, 1'b0);
            FORM_VX: second = fitTo(MW'({{(MW){scalarReg[XLEN-1]}}, scalarReg}), (XLEN < ew) ? XLEN : ew,
                1'b1);
            default: second = fitTo(MW'(operands.imm), `VAS_IMM_W, 1'b1);
        endcase
        second = fitTo(second, ew, 1'b0);
        isWide = 1'b0;
        wSigned = 1'b0;
        doSub = 1'b0;
        cin = 1'b0;
        extBits = ew;
        extSigned = 1'b0;
        opA = fitTo(operands.first, ew, 1'b0);
        opB = second;
        outBits = ew;
        rsv_nxt = 1'b0;
        unique case (ctrl.op)
            OP_ADD: ;
            OP_SUB:
            begin
                doSub = 1'b1;
                rsv_nxt = (ctrl.form == FORM_VI);
            end
            OP_RSUB:
            begin
                opA = second;
                opB = fitTo(operands.first, ew, 1'b0);
                doSub = 1'b1;
                rsv_nxt = (ctrl.form == FORM_VV);
            end
            OP_WADDU, OP_WADD, OP_WSUBU, OP_WSUB, OP_WADDU_W, OP_WADD_W, OP_WSUBU_W, OP_WSUB_W:
            begin
                isWide = 1'b1;
                outBits = 2 * ew;
                wSigned = ctrl.op inside {OP_WADD, OP_WSUB, OP_WADD_W, OP_WSUB_W};
                doSub = ctrl.op inside {OP_WSUBU, OP_WSUB, OP_WSUBU_W, OP_WSUB_W};
                if (ctrl.op inside {OP_WADDU_W, OP_WADD_W, OP_WSUBU_W, OP_WSUB_W})
                    opA = fitTo(operands.first, 2 * ew, 1'b0);
                else
                    opA = fitTo(fitTo(operands.first, ew, 1'b0), ew, wSigned);
                opB = fitTo(second, ew, wSigned);
                rsv_nxt = (ctrl.form == FORM_VI) || (ctrl.elemWidth == `VAS_EW64) ||
                    (ctrl.groupMul == `VAS_MUL_MAX);
            end
            OP_ZEXT2, OP_SEXT2, OP_ZEXT4, OP_SEXT4, OP_ZEXT8, OP_SEXT8:
            begin
                extBits = ew >> extShift(ctrl.op);
                extSigned = ctrl.op inside {OP_SEXT2, OP_SEXT4, OP_SEXT8};
                opA = (extBits >= 8) ? fitTo(operands.first, extBits, extSigned) : '0;
                opB = '0;
                // source multiplier is scaled down by the same ratio
                // a whole-register group never scales below the smallest fraction
                rsv_nxt = (extBits < 8) ||
                    ((ctrl.groupMul >= `VAS_MUL_FRAC) &&
                    (ctrl.groupMul - `VAS_MUL_MIN < 3'(extShift(ctrl.op))));
            end
            OP_ADC, OP_SBC:
            begin
                doSub = (ctrl.op == OP_SBC);
                cin = operands.carryIn;
                rsv_nxt = ctrl.maskEnable || (ctrl.destReg == 5'h00) ||
                    (doSub && ctrl.form == FORM_VI);
            end
            OP_MADC, OP_MSBC:
            begin
                doSub = (ctrl.op == OP_MSBC);
                cin = ~ctrl.maskEnable & operands.carryIn;
                rsv_nxt = doSub && ctrl.form == FORM_VI;
            end
            default:
            begin
                rsv_nxt = (ctrl.form == FORM_VI);
            end
        endcase
        // the verdict stands until the next request is taken
        if (!inValid)
            rsv_nxt = rsv_r;
    end

    always_comb
    begin
        // multiply-add: accumulate into old dest or overwrite multiplicand
        if (ctrl.op == OP_MACC)
            prod = second * fitTo(operands.first, ew, 1'b0) + operands.oldDest;
        else
            prod = second * operands.oldDest + fitTo(operands.first, ew, 1'b0);
        fullSum = laneSum;
    end

    always_comb
    begin
        valid_nxt = inValid;
        res_nxt = res_r;
        if (inValid)
        begin
            res_nxt.isMask = ctrl.op inside {OP_MADC, OP_MSBC};
            res_nxt.tailAgnostic = res_nxt.isMask;
            // carry is the bit just above the element width
            res_nxt.maskBit = laneWide[ew];
            res_nxt.destWidth = isWide ? ctrl.elemWidth + 2'h1 : ctrl.elemWidth;
            res_nxt.destMul = isWide ? mulShift(ctrl.groupMul, 1) : ctrl.groupMul;
            if (ctrl.op inside {OP_MACC, OP_MADD})
                res_nxt.value = fitTo(prod, ew, 1'b0);
            else if (res_nxt.isMask)
                res_nxt.value = '0;
            else
                res_nxt.value = fitTo(fullSum, outBits, 1'b0);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            valid_r <= 1'b0;
            res_r <= '0;
            rsv_r <= 1'b0;
        end
        else
        begin
            valid_r <= valid_nxt;
            res_r <= res_nxt;
            rsv_r <= rsv_nxt;
        end
    end

    assign outValid = valid_r;
    assign result = res_r;
    assign reserved = rsv_r;
endmodule

/* File: verif/vaddsub_unit_props.sv */
// concurrent checks on the ports of the add/subtract unit
`timescale 1ns/1ps
`include "vaddsub_params.svh"
module vaddsub_unit_props
    import vaddsub_pkg::*;
#(
    parameter int XLEN = 64
)(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request and answer
    input wire logic inValid,
    input wire ctrl_s ctrl,
    input wire operands_s operands,
    input wire logic [XLEN-1:0] scalarReg,
    input wire logic outValid,
    input wire result_s result,
    input wire logic reserved
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [8:0] sum9;
    logic carry8;
    logic [7:0] add8;
    logic [7:0] rsub8;
    logic ew8;
    assign sum9 = {1'b0, operands.first[7:0]} + {1'b0, operands.second[7:0]} +
        {8'h0, operands.carryIn & ~ctrl.maskEnable};
    assign carry8 = sum9[8];
    assign add8 = operands.first[7:0] + operands.second[7:0];
    assign rsub8 = {{3{operands.imm[4]}}, operands.imm} - operands.first[7:0];
    assign ew8 = ctrl.elemWidth == `VAS_EW8;

    a_answer_next: assert property (inValid |=> outValid) else $error("no answer");
    a_no_stray: assert property (!inValid |=> !outValid) else $error("stray answer");
    a_add_wrap: assert property (inValid && ctrl.op == OP_ADD && ctrl.form == FORM_VV && ew8
        |=> result.value == {56'h0, $past(add8)}) else $error("add");
    a_rsub_imm: assert property (inValid && ctrl.op == OP_RSUB && ctrl.form == FORM_VI && ew8
        |=> result.value[7:0] == $past(rsub8))
        else $error("rsub");
    a_carry_out: assert property (inValid && ctrl.op == OP_MADC && ctrl.form == FORM_VV && ew8
        |=> result.maskBit == $past(carry8)) else $error("carry");
    a_widen_size: assert property (inValid && ctrl.op inside {[OP_WADDU:OP_WSUB_W]}
        && ctrl.elemWidth != `VAS_EW64
        && ctrl.groupMul != `VAS_MUL_MAX |=> result.destWidth == $past(ctrl.elemWidth) + 2'h1
        && result.destMul == $past(ctrl.groupMul) + 3'h1) else $error("widen size");
    a_carry_rsvd: assert property (inValid && ctrl.op inside {OP_ADC, OP_SBC}
        && (ctrl.maskEnable || ctrl.destReg == 5'h0) |=> reserved) else $error("carry reserved");
    a_mask_tail: assert property (inValid && ctrl.op inside {OP_MADC, OP_MSBC}
        |=> result.isMask && result.tailAgnostic) else $error("mask tail");
    a_hold_answer: assert property (outValid && !inValid |=> $stable(result) && $stable(reserved))
        else $error("answer moved");
    c_madc: cover property (inValid && ctrl.op == OP_MADC);
    c_widen: cover property (inValid && ctrl.op == OP_WADD);
    c_rsvd: cover property (outValid && reserved);
endmodule

bind vaddsub_unit vaddsub_unit_props #(.XLEN(XLEN)) u_props (.clk(clk), .rst_n(rst_n), .inValid(inValid),
    .ctrl(ctrl), .operands(operands), .scalarReg(scalarReg), .outValid(outValid), .result(result),
    .reserved(reserved));

/* File: verif/vaddsub_issue_model.sv */
// issue-side model presenting one element request at a time
`timescale 1ns/1ps
module vaddsub_issue_model
    import vaddsub_pkg::*;
(
    // clock
    input wire logic clk,
    // request to the unit
    output logic inValid,
    output ctrl_s ctrl,
    output operands_s operands,
    output logic [63:0] scalarReg
);
    initial
    begin
        inValid = 1'b0;
        ctrl = '0;
        operands = '0;
        scalarReg = '0;
    end
    // after the taken edge all fields are inverted, so stale values are never mistaken for live ones
    task automatic send(input ctrl_s c, input operands_s o, input logic [63:0] x);
        @(negedge clk);
        inValid <= 1'b1;
        ctrl <= c;
        operands <= o;
        scalarReg <= x;
        @(negedge clk);
        inValid <= 1'b0;
        ctrl <= ctrl_s'(~c);
        operands <= ~o;
        scalarReg <= ~x;
    endtask
endmodule

/* File: verif/vaddsub_unit_test.sv */
// self-checking bench for the add/subtract unit
`timescale 1ns/1ps
`include "vaddsub_params.svh"
module vaddsub_unit_test
    import vaddsub_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic inValid;
    logic outValid;
    logic reserved;
    ctrl_s ctrl;
    operands_s operands;
    logic [63:0] scalarReg;
    result_s result;
    int failures = 0;
    int comparisons = 0;

    initial
    begin
        forever #5 clk = ~clk;
    end

    vaddsub_issue_model u_issue (.clk(clk), .inValid(inValid), .ctrl(ctrl), .operands(operands),
        .scalarReg(scalarReg));
    vaddsub_unit #(.XLEN(64)) u_dut (.clk(clk), .rst_n(rst_n), .inValid(inValid), .ctrl(ctrl),
        .operands(operands), .scalarReg(scalarReg), .outValid(outValid), .result(result), .reserved(reserved));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic run(input op_e op, input form_e f, input logic [1:0] ew, input logic [63:0] a,
        input logic [63:0] b, input logic [63:0] x = 0, input logic [4:0] imm = 0, input logic cin = 0,
        input logic me = 0, input logic [4:0] rd = 5'h1, input logic [63:0] od = 0, input logic [2:0] gm = 3'h0);
        u_issue.send('{op, f, ew, gm, me, rd}, '{a, b, 64'h0, imm, od, cin}, x);
        chk({63'h0, outValid}, 64'h1);
    endtask

    task automatic t_add();
        run(OP_ADD, FORM_VV, `VAS_EW8, 64'hF0, 64'h20);
        chk(result.value, 64'h10);
        chk({63'h0, reserved}, 64'h0);
        run(OP_ADD, FORM_VX, `VAS_EW16, 64'h3, 0, 64'h5_FFFF);
        chk(result.value, 64'h2);
        run(OP_ADD, FORM_VI, `VAS_EW32, 64'h10, 0, 0, 5'h1F);
        chk(result.value, 64'hF);
        run(OP_SUB, FORM_VX, `VAS_EW8, 64'h5, 0, 64'h7);
        chk(result.value, 64'hFE);
        run(OP_SUB, FORM_VI, `VAS_EW8, 64'h5, 0);
        chk({63'h0, reserved}, 64'h1);
    endtask

    task automatic t_rsub();
        run(OP_RSUB, FORM_VI, `VAS_EW8, 64'h5, 0, 0, 5'h3);
        chk(result.value, 64'hFE);
        run(OP_RSUB, FORM_VV, `VAS_EW8, 64'h5, 64'h3);
        chk({63'h0, reserved}, 64'h1);
    endtask

    task automatic t_widen();
        run(OP_WADDU, FORM_VV, `VAS_EW8, 64'hFF, 64'hFF);
        chk(result.value, 64'h1FE);
        run(OP_WADD, FORM_VV, `VAS_EW8, 64'hFF, 64'hFF);
        chk(result.value, 64'hFFFE);
        chk({62'h0, result.destWidth}, 64'h1);
        run(OP_WSUBU, FORM_VV, `VAS_EW8, 64'h0, 64'h1);
        chk(result.value, 64'hFFFF);
        run(OP_WADD_W, FORM_VV, `VAS_EW8, 64'h100, 64'hFF);
        chk(result.value, 64'hFF);
        run(OP_WADDU, FORM_VV, `VAS_EW64, 64'h1, 64'h1);
        chk({63'h0, reserved}, 64'h1);
        run(OP_WADDU, FORM_VV, `VAS_EW16, 64'h1, 64'h2, 0, 0, 1'b0, 1'b0, 5'h1, 0, 3'h6);
        chk(result.value, 64'h3);
        chk({61'h0, result.destMul}, 64'h7);
        chk({62'h0, result.destWidth}, 64'h2);
        chk({63'h0, reserved}, 64'h0);
        run(OP_WADDU, FORM_VV, `VAS_EW8, 64'h1, 64'h1, 0, 0, 1'b0, 1'b0, 5'h1, 0, `VAS_MUL_MAX);
        chk({63'h0, reserved}, 64'h1);
    endtask

    task automatic t_ext();
        run(OP_SEXT4, FORM_VV, `VAS_EW32, 64'h80, 0);
        chk(result.value, 64'hFFFF_FF80);
        run(OP_ZEXT2, FORM_VV, `VAS_EW16, 64'h80, 0);
        chk(result.value, 64'h80);
        run(OP_ZEXT8, FORM_VV, `VAS_EW32, 64'h8, 0);
        chk({63'h0, reserved}, 64'h1);
        run(OP_SEXT2, FORM_VV, `VAS_EW16, 64'h80, 0, 0, 0, 1'b0, 1'b0, 5'h1, 0, 3'h6);
        chk(result.value, 64'hFF80);
        chk({63'h0, reserved}, 64'h0);
        run(OP_SEXT2, FORM_VV, `VAS_EW16, 64'h80, 0, 0, 0, 1'b0, 1'b0, 5'h1, 0, `VAS_MUL_MIN);
        chk({63'h0, reserved}, 64'h1);
        run(OP_ZEXT8, FORM_VV, `VAS_EW64, 64'h80, 0, 0, 0, 1'b0, 1'b0, 5'h1, 0, 3'h7);
        chk({63'h0, reserved}, 64'h1);
    endtask

    task automatic t_muladd();
        run(OP_MACC, FORM_VV, `VAS_EW8, 64'h3, 64'h4, 0, 0, 1'b0, 1'b0, 5'h1, 64'hFF);
        chk(result.value, 64'h0B);
        run(OP_MADD, FORM_VV, `VAS_EW8, 64'h10, 64'h4, 0, 0, 1'b0, 1'b0, 5'h1, 64'h3);
        chk(result.value, 64'h1C);
        run(OP_MACC, FORM_VX, `VAS_EW8, 64'h3, 0, 64'h5, 0, 1'b0, 1'b0, 5'h1, 64'h1);
        chk(result.value, 64'h10);
        run(OP_MACC, FORM_VI, `VAS_EW8, 64'h3, 0, 0, 5'h2);
        chk({63'h0, reserved}, 64'h1);
    endtask

    task automatic t_carry();
        run(OP_MADC, FORM_VV, `VAS_EW8, 64'hFF, 64'h0, 0, 0, 1'b1);
        chk({63'h0, result.maskBit}, 64'h1);
        run(OP_MADC, FORM_VV, `VAS_EW8, 64'hFF, 64'h0, 0, 0, 1'b1, 1'b1);
        chk({63'h0, result.maskBit}, 64'h0);
        run(OP_ADC, FORM_VV, `VAS_EW8, 64'hFF, 64'h0, 0, 0, 1'b1);
        chk(result.value, 64'h0);
        run(OP_ADC, FORM_VV, `VAS_EW8, 64'h1, 64'h1, 0, 0, 1'b0, 1'b1);
        chk({63'h0, reserved}, 64'h1);
        run(OP_ADC, FORM_VV, `VAS_EW8, 64'h1, 64'h1, 0, 0, 1'b0, 1'b0, 5'h0);
        chk({63'h0, reserved}, 64'h1);
        run(OP_MSBC, FORM_VV, `VAS_EW8, 64'h0, 64'h0, 0, 0, 1'b1);
        chk({63'h0, result.maskBit}, 64'h1);
        run(OP_SBC, FORM_VV, `VAS_EW8, 64'h10, 64'h1, 0, 0, 1'b1);
        chk(result.value, 64'hE);
    endtask

    task automatic end_of_test();
        if (failures == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_add();
        t_rsub();
        t_widen();
        t_ext();
        t_carry();
        t_muladd();
        end_of_test();
    end

    // the tests need well under a thousand cycles
    initial
    begin
        #20000;
        failures++;
        end_of_test();
    end
endmodule
